// ===== src/rvp_pkg.sv
// constants for reset and interrupt vector placement
package rvp_pkg;
    localparam int ADDR_W = 16;
    localparam int NUM_SRC = 25;
    localparam int NUM_W = 5;
    localparam logic [ADDR_W-1:0] RESET_ADDR_APP = 16'h0000;
    localparam logic [ADDR_W-1:0] VEC_START_APP = 16'h0002;
    localparam logic [ADDR_W-1:0] VEC_STRIDE = 16'h0002;
    localparam logic [NUM_W-1:0] RESET_VECTOR_NO = 5'h01;
    localparam logic [NUM_W-1:0] FIRST_IRQ_VECTOR_NO = 5'h02;
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;
    // table address of each request, index 0 is vector 2
    localparam logic [ADDR_W-1:0] VEC_TABLE [NUM_SRC] = '{
        16'h0002, 16'h0004,
        16'h0006, 16'h0008, 16'h000a,
        16'h000c,
        16'h000e, 16'h0010, 16'h0012,
        16'h0014, 16'h0016, 16'h0018, 16'h001a,
        16'h001c, 16'h001e, 16'h0020,
        16'h0022,
        16'h0024, 16'h0026, 16'h0028,
        16'h002a, 16'h002c, 16'h002e, 16'h0030, 16'h0032
    };
endpackage : rvp_pkg

// ===== src/rvp_req_if.sv
// request set and encoded winner between the vector block and its encoder
`timescale 1ns/10ps
interface rvp_req_if;
    import rvp_pkg::*;
    logic [NUM_SRC-1:0] req;
    logic hit;
    logic [NUM_W-1:0] idx;
    modport enc (input req, output hit, output idx);
    modport user (output req, input hit, input idx);
endinterface : rvp_req_if

// ===== src/rvp_prio.sv
// lowest-index priority encoder for pending requests
`timescale 1ns/10ps
module rvp_prio (
    rvp_req_if.enc bus
);
    import rvp_pkg::*;

    always_comb begin
        bus.hit = 1'b0;
        bus.idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (bus.req[i]) begin
                bus.hit = 1'b1;
                bus.idx = NUM_W'(i);
            end
        end
    end
endmodule : rvp_prio

// ===== src/rvp_vector.sv
// reset and interrupt vector address generator
// Notes on behaviour
// - vector 1 resets at 0x0000 unless the boot reset fuse is programmed.
// - external request zero at 0x0002, request one at 0x0004.
// - pin-change groups zero, one, two at 0x0006, 0x0008, 0x000a.
// - watchdog timeout is vector 7 at 0x000c.
// - second 8-bit timer match a, match b, overflow at 0x000e..0x0012.
// - 16-bit timer capture, match a, match b, overflow at 0x0014..0x001a.
// - first 8-bit timer match a, match b, overflow at 0x001c..0x0020.
// - serial peripheral transfer complete at 0x0022.
// - serial port receive, buffer empty, transmit done at 0x0024..0x0028.
// - converter, nv data, comparator, two-wire, program store at 0x002a..0x0032.
// - table select set adds boot start to every interrupt vector.
// - programmed boot reset fuse moves reset address to boot start.
// - reset and vector start addresses are chosen independently.
// - fuse stored 1 means unprogrammed, stored 0 means programmed.
// - each vector spans two words; neighbours differ by two.
`timescale 1ns/10ps
module rvp_vector (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // requests and placement from the core
    input wire logic [rvp_pkg::NUM_SRC-1:0] IRQ_REQ,
    input wire logic VECTOR_TABLE_SELECT,
    // fuse levels from outside the clock domain
    input wire logic BOOT_RESET_FUSE,
    input wire logic [rvp_pkg::ADDR_W-1:0] BOOT_START_ADDR,
    // vector to the core
    output logic VECTOR_VALID,
    output logic [rvp_pkg::NUM_W-1:0] VECTOR_NUM,
    output logic [rvp_pkg::ADDR_W-1:0] VECTOR_ADDR,
    // reset entry to the core
    output logic RESET_ADDR_VALID,
    output logic [rvp_pkg::ADDR_W-1:0] RESET_ADDR
);
    import rvp_pkg::*;

    function automatic logic [ADDR_W-1:0] vec_addr(input logic [NUM_W-1:0] idx,
                                                   input logic sel,
                                                   input logic [ADDR_W-1:0] boot);
        logic [ADDR_W-1:0] base;
        base = sel ? boot : '0;
        return base + VEC_TABLE[idx];
    endfunction : vec_addr

    rvp_req_if req_bus ();
    assign req_bus.req = IRQ_REQ;

    rvp_prio u_prio (
        .bus (req_bus)
    );

    // fuse synchronisers
    logic fuse_s1_reg, fuse_s2_reg;
    logic [ADDR_W-1:0] boot_s1_reg, boot_s2_reg;
    logic [1:0] settle_reg, settle_next;
    logic rst_valid_reg, rst_valid_next;
    logic [ADDR_W-1:0] rst_addr_reg, rst_addr_next;
    logic vec_valid_reg, vec_valid_next;
    logic [NUM_W-1:0] vec_num_reg, vec_num_next;
    logic [ADDR_W-1:0] vec_addr_reg, vec_addr_next;

    always_comb begin
        settle_next = settle_reg;
        rst_valid_next = rst_valid_reg;
        if (settle_reg != SETTLE_CYCLES) begin
            settle_next = settle_reg + 2'h1;
        end else begin
            rst_valid_next = 1'b1;
        end
        if (fuse_s2_reg == FUSE_PROGRAMMED) begin
            rst_addr_next = boot_s2_reg;
        end else begin
            rst_addr_next = RESET_ADDR_APP;
        end
    end

    always_comb begin
        vec_valid_next = req_bus.hit;
        vec_num_next = vec_num_reg;
        vec_addr_next = vec_addr_reg;
        if (req_bus.hit) begin
            vec_num_next = req_bus.idx + FIRST_IRQ_VECTOR_NO;
            vec_addr_next = vec_addr(req_bus.idx, VECTOR_TABLE_SELECT, boot_s2_reg);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fuse_s1_reg <= 1'b1;
            fuse_s2_reg <= 1'b1;
            boot_s1_reg <= '0;
            boot_s2_reg <= '0;
        end else begin
            fuse_s1_reg <= BOOT_RESET_FUSE;
            fuse_s2_reg <= fuse_s1_reg;
            boot_s1_reg <= BOOT_START_ADDR;
            boot_s2_reg <= boot_s1_reg;
        end
    end

    // reset entry registers
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            settle_reg <= 2'h0;
            rst_valid_reg <= 1'b0;
            rst_addr_reg <= RESET_ADDR_APP;
        end else begin
            settle_reg <= settle_next;
            rst_valid_reg <= rst_valid_next;
            rst_addr_reg <= rst_addr_next;
        end
    end

    // vector registers
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            vec_valid_reg <= 1'b0;
            vec_num_reg <= RESET_VECTOR_NO;
            vec_addr_reg <= VEC_START_APP;
        end else begin
            vec_valid_reg <= vec_valid_next;
            vec_num_reg <= vec_num_next;
            vec_addr_reg <= vec_addr_next;
        end
    end

    assign VECTOR_VALID = vec_valid_reg;
    assign VECTOR_NUM = vec_num_reg;
    assign VECTOR_ADDR = vec_addr_reg;
    assign RESET_ADDR_VALID = rst_valid_reg;
    assign RESET_ADDR = rst_addr_reg;

    // checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    property p_reset_app;
        (settle_reg == SETTLE_CYCLES) && fuse_s2_reg |=> RESET_ADDR == 16'h0000;
    endproperty
    a_reset_app: assert property (p_reset_app) else $error("reset address not zero");
    property p_reset_boot;
        (settle_reg == SETTLE_CYCLES) && !fuse_s2_reg |=> RESET_ADDR == $past(boot_s2_reg);
    endproperty
    a_reset_boot: assert property (p_reset_boot) else $error("reset not at boot");
    property p_reset_ready;
        $rose(RESET_ADDR_VALID) |-> $past(settle_reg) == SETTLE_CYCLES;
    endproperty
    a_reset_ready: assert property (p_reset_ready) else $error("reset valid early");
    property p_ext_one;
        IRQ_REQ == 25'h0000002 && !VECTOR_TABLE_SELECT |=> VECTOR_ADDR == 16'h0004;
    endproperty
    a_ext_one: assert property (p_ext_one) else $error("ext one vector wrong");
    property p_watchdog;
        IRQ_REQ == 25'h0000020 && !VECTOR_TABLE_SELECT
            |=> VECTOR_ADDR == 16'h000c && VECTOR_NUM == 5'h07;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog vector wrong");
    property p_last;
        IRQ_REQ == 25'h1000000 && !VECTOR_TABLE_SELECT |=> VECTOR_ADDR == 16'h0032;
    endproperty
    a_last: assert property (p_last) else $error("program store vector wrong");
    property p_boot_move;
        IRQ_REQ == 25'h0000001 && VECTOR_TABLE_SELECT
            |=> VECTOR_ADDR == $past(boot_s2_reg) + VEC_START_APP;
    endproperty
    a_boot_move: assert property (p_boot_move) else $error("moved vector wrong");
    property p_stride;
        (IRQ_REQ == 25'h0000004 && !VECTOR_TABLE_SELECT)
            ##1 (IRQ_REQ == 25'h0000008 && !VECTOR_TABLE_SELECT)
            |=> VECTOR_ADDR == $past(VECTOR_ADDR) + VEC_STRIDE;
    endproperty
    a_stride: assert property (p_stride) else $error("vector stride wrong");
    property p_lowest;
        IRQ_REQ[0] |=> VECTOR_VALID && VECTOR_NUM == 5'h02;
    endproperty
    a_lowest: assert property (p_lowest) else $error("lowest request lost");
    property p_idle;
        IRQ_REQ == '0 |=> !VECTOR_VALID;
    endproperty
    a_idle: assert property (p_idle) else $error("vector without request");
    property p_valid_any;
        IRQ_REQ != '0 |=> VECTOR_VALID;
    endproperty
    a_valid_any: assert property (p_valid_any) else $error("pending request lost");
    property p_hold;
        !VECTOR_VALID |-> $stable(VECTOR_NUM) && $stable(VECTOR_ADDR);
    endproperty
    a_hold: assert property (p_hold) else $error("idle vector changed");
    property p_num_addr;
        VECTOR_VALID && !$past(VECTOR_TABLE_SELECT)
            |-> VECTOR_ADDR == {10'h000, VECTOR_NUM - 5'h01, 1'b0};
    endproperty
    a_num_addr: assert property (p_num_addr) else $error("number and address disagree");
    property p_boot_entry;
        RESET_ADDR_VALID && $past(BOOT_RESET_FUSE, 3) == FUSE_PROGRAMMED
            |-> RESET_ADDR == $past(BOOT_START_ADDR, 3);
    endproperty
    a_boot_entry: assert property (p_boot_entry) else $error("boot entry not from pins");
    property p_app_entry;
        RESET_ADDR_VALID && $past(BOOT_RESET_FUSE, 3) != FUSE_PROGRAMMED
            |-> RESET_ADDR == RESET_ADDR_APP;
    endproperty
    a_app_entry: assert property (p_app_entry) else $error("app entry not zero");
    property p_split;
        RESET_ADDR_VALID && RESET_ADDR != RESET_ADDR_APP && !VECTOR_TABLE_SELECT
            && IRQ_REQ == 25'h0000001
            |=> VECTOR_ADDR == VEC_START_APP;
    endproperty
    a_split: assert property (p_split) else $error("vector start follows reset");

    property p_cov_moved;
        VECTOR_VALID && VECTOR_ADDR > 16'h0032;
    endproperty
    c_cov_moved: cover property (p_cov_moved);
    property p_cov_boot_reset;
        RESET_ADDR_VALID && RESET_ADDR != 16'h0000;
    endproperty
    c_cov_boot_reset: cover property (p_cov_boot_reset);
    property p_cov_many;
        $countones(IRQ_REQ) > 1 ##1 VECTOR_VALID;
    endproperty
    c_cov_many: cover property (p_cov_many);
    property p_cov_table_move;
        $rose(VECTOR_TABLE_SELECT);
    endproperty
    c_cov_table_move: cover property (p_cov_table_move);
endmodule : rvp_vector

// ===== sim/rvp_core_model.sv
// core-side model presenting requests and table select
`timescale 1ns/10ps
module rvp_core_model (
    // clock
    input wire logic clk,
    // to the vector block
    output logic [rvp_pkg::NUM_SRC-1:0] req,
    output logic sel
);
    import rvp_pkg::*;
    initial begin
        req = '0;
        sel = 1'b0;
    end
    // caller stands just after a falling edge of clk
    task automatic post(input logic [NUM_SRC-1:0] r, input logic s);
        if (s != sel) begin
            // requests stay quiet while the table moves
            req = '0;
            @(negedge clk);
            sel = s;
            @(negedge clk);
        end
        req = r;
    endtask : post
endmodule : rvp_core_model

// ===== sim/testbench.sv
// self-checking bench for the vector placement block
`timescale 1ns/10ps
module testbench;
    import rvp_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic fuse = 1'b1;
    logic [ADDR_W-1:0] boot = 16'h3c00;
    logic [NUM_SRC-1:0] req;
    logic sel, vld, rvld;
    logic [NUM_W-1:0] num;
    logic [ADDR_W-1:0] vaddr, raddr;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    rvp_core_model u_core (.clk(clk), .req(req), .sel(sel));
    rvp_vector u_dut (.CORE_CLK(clk), .RESET_N(reset_n), .IRQ_REQ(req),
        .VECTOR_TABLE_SELECT(sel), .BOOT_RESET_FUSE(fuse), .BOOT_START_ADDR(boot),
        .VECTOR_VALID(vld), .VECTOR_NUM(num), .VECTOR_ADDR(vaddr),
        .RESET_ADDR_VALID(rvld), .RESET_ADDR(raddr));
    task automatic check(input string what, input logic [ADDR_W-1:0] seen,
                         input logic [ADDR_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic do_reset(input logic f);
        @(negedge clk);
        reset_n = 1'b0;
        fuse = f;
        u_core.post('0, 1'b0);
        @(negedge clk);
        check("reset vld", ADDR_W'(vld), 16'h0000);
        check("reset num", ADDR_W'(num), 16'h0001);
        repeat (19) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        check("early rst valid", ADDR_W'(rvld), 16'h0000);
        @(negedge clk);
        check("rst valid", ADDR_W'(rvld), 16'h0001);
        check("rst addr", raddr, f ? 16'h0000 : boot);
    endtask : do_reset
    task automatic prio();
        u_core.post({NUM_SRC{1'b1}}, 1'b0);
        @(negedge clk);
        check("all num", ADDR_W'(num), 16'h0002);
        u_core.post(25'h1000040, 1'b0);
        @(negedge clk);
        check("pair num", ADDR_W'(num), 16'h0008);
        check("pair addr", vaddr, 16'h000e);
        u_core.post('0, 1'b0);
        @(negedge clk);
        check("none vld", ADDR_W'(vld), 16'h0000);
        check("held num", ADDR_W'(num), 16'h0008);
    endtask : prio
    task automatic scan(input logic s);
        logic [ADDR_W-1:0] base;
        base = s ? boot : 16'h0000;
        for (int i = 0; i < NUM_SRC; i++) begin
            u_core.post(NUM_SRC'(1) << i, s);
            @(negedge clk);
            check("vec vld", ADDR_W'(vld), 16'h0001);
            check("vec num", ADDR_W'(num), ADDR_W'(i + 2));
            check("vec addr", vaddr, base + ADDR_W'(2 * i + 2));
        end
    endtask : scan
    initial begin
        do_reset(1'b1);
        prio();
        scan(1'b0);
        scan(1'b1);
        boot = 16'h3800;
        do_reset(1'b0);
        scan(1'b0);
        scan(1'b1);
        give_verdict();
    end
endmodule : testbench
